// >>> src/pdi_cfg.svh
// constants for the partial display and line inversion command decoder
`ifndef PDI_CFG_SVH
`define PDI_CFG_SVH

// command opcodes, all taken with command_data_select low
`define OP_DUTY_BASE      8'h30
`define OP_DUTY_LAST      8'h34
`define OP_DUTY_RSV_LAST  8'h37
`define OP_BIAS_BASE      8'h38
`define OP_BIAS_LAST      8'h3D
`define OP_BIAS_RSV_LAST  8'h3F
`define OP_MODE_NORMAL    8'h82
`define OP_MODE_PARTIAL   8'h83
`define OP_INV_RELEASE    8'h84
`define OP_INV_SET        8'h85
`define OP_START_SET      8'hD3
`define OP_PUMP_SET       8'hE6

// duty codes: 0 = 1/9, 1 = 1/17, 2 = 1/33, 3 = 1/49, 4 = 1/65
`define DUTY_9            3'h0
`define DUTY_17           3'h1
`define DUTY_33           3'h2
`define DUTY_49           3'h3
`define DUTY_65           3'h4

// scanned lines per duty code, icon common not counted
`define LINES_9           7'h08
`define LINES_17          7'h10
`define LINES_33          7'h20
`define LINES_49          7'h30
`define LINES_65          7'h40

// bias codes: 0 = 1/4 ... 5 = 1/9; bias loaded together with each duty
`define BIAS_FOR_9        3'h0
`define BIAS_FOR_17       3'h1
`define BIAS_FOR_33       3'h2
`define BIAS_FOR_49       3'h3
`define BIAS_FOR_65       3'h5

// field positions inside the second byte of the pairs
`define START_MSB         5
`define INV_MSB           4
`define PUMP_MSB          3

// index of the icon common on com_line_i
`define ICON_COM          7'h40

// reset values
`define RST_DUTY          3'h4
`define RST_BIAS          3'h5
`define RST_START         6'h00
`define RST_INV_COUNT     5'h00
`define RST_PUMP_DIV      4'h3

`endif

// >>> src/pdi_pkg.sv
// types shared by the partial display and inversion command decoder
package pdi_pkg;

	// pending second byte of a two-byte command, one-hot
	typedef enum logic [3:0] {
		PEND_NONE  = 4'b0001,
		PEND_START = 4'b0010,
		PEND_INV   = 4'b0100,
		PEND_PUMP  = 4'b1000
	} pend_state_type;

	typedef logic [2:0] duty_code_type;
	typedef logic [2:0] bias_code_type;

endpackage

// >>> src/duty_limit.sv
// effective duty, scan length and start line after the pin limit
`timescale 1ns/100ps
`include "pdi_cfg.svh"
module duty_limit
	import pdi_pkg::*;
(
	input  wire logic          partial_mode_i,
	input  wire duty_code_type req_duty_i,
	input  wire logic [5:0]    req_start_i,
	input  wire logic          max_duty_pin_lo_i,
	input  wire logic          max_duty_pin_hi_i,
	output duty_code_type      eff_duty_o,
	output logic [6:0]         eff_lines_o,
	output logic [5:0]         eff_start_o
);

	duty_code_type max_duty;   // ceiling fixed by the two strap pins
	logic [6:0]    max_lines;  // lines scanned at that ceiling

	// strap decode: hi set gives 1/65, else lo picks 1/49 or 1/33
	always_comb begin
		if (max_duty_pin_hi_i) begin
			max_duty  = `DUTY_65;
			max_lines = `LINES_65;
		end else if (max_duty_pin_lo_i) begin
			max_duty  = `DUTY_49;
			max_lines = `LINES_49;
		end else begin
			max_duty  = `DUTY_33;
			max_lines = `LINES_33;
		end
	end

	// partial duty clamps at the pin ceiling; normal mode uses the pins
	always_comb begin
		if (!partial_mode_i) begin
			eff_duty_o = max_duty;
		end else if (req_duty_i > max_duty) begin
			eff_duty_o = max_duty;
		end else begin
			eff_duty_o = req_duty_i;
		end
	end

	// scanned line count for the chosen duty
	always_comb begin
		case (eff_duty_o)
			`DUTY_9:  eff_lines_o = `LINES_9;
			`DUTY_17: eff_lines_o = `LINES_17;
			`DUTY_33: eff_lines_o = `LINES_33;
			`DUTY_49: eff_lines_o = `LINES_49;
			default:  eff_lines_o = `LINES_65;
		endcase
	end

	// a start line past the pin ceiling falls back to line zero
	always_comb begin
		if ({1'b0, req_start_i} >= max_lines) begin
			eff_start_o = 6'h00;
		end else begin
			eff_start_o = req_start_i;
		end
	end

endmodule

// >>> src/pump_divider.sv
// charge pump clock enable, divided from the oscillator tick
`timescale 1ns/100ps
module pump_divider (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       osc_tick_i,
	input  wire logic [3:0] div_sel_i,
	output logic            pump_tick_o
);

	logic [4:0] cnt_q;   // oscillator ticks seen in this pump period
	logic [4:0] limit;   // 2n ticks per pump pulse

	// select zero passes every tick; n gives one pulse per 2n ticks
	assign limit = {div_sel_i, 1'b0};

	// tick counter; restarts when the pulse fires, and a new select
	// already sets the end of the running period without a long runaway
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			cnt_q       <= 5'h00;
			pump_tick_o <= 1'b0;
		end else if (!osc_tick_i) begin
			pump_tick_o <= 1'b0;
		end else if (div_sel_i == 4'h0) begin
			cnt_q       <= 5'h00;
			pump_tick_o <= 1'b1;
		end else if (cnt_q + 5'h01 >= limit) begin
			cnt_q       <= 5'h00;
			pump_tick_o <= 1'b1;
		end else begin
			cnt_q       <= cnt_q + 5'h01;
			pump_tick_o <= 1'b0;
		end
	end

endmodule

// >>> src/partial_display_inversion_cmds.sv
// command decoder for partial display, line inversion and pump clock
`timescale 1ns/100ps
`include "pdi_cfg.svh"

module partial_display_inversion_cmds
	import pdi_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       wr_strobe_i,
	input  wire logic       command_data_select_i,
	input  wire logic [7:0] wr_byte_i,
	input  wire logic       max_duty_pin_lo_i,
	input  wire logic       max_duty_pin_hi_i,
	input  wire logic       osc_tick_i,
	input  wire logic [6:0] com_line_i,
	output logic            partial_mode_o,
	output duty_code_type   duty_o,
	output bias_code_type   partial_bias_o,
	output logic [6:0]      scan_lines_o,
	output logic [5:0]      start_line_o,
	output logic            line_inv_en_o,
	output logic [5:0]      line_inv_lines_o,
	output logic            pair_pending_o,
	output logic            com_select_o,
	output logic            icon_common_output_o,
	output logic            pump_tick_o
);

	// ------------------------------------------------------------
	// byte acceptance
	// ------------------------------------------------------------

	logic cmd_take;   // a command byte lands this cycle

	// only writes with command_data_select low are commands; display
	// data writes belong to the ram path and never touch this block
	assign cmd_take = wr_strobe_i && !command_data_select_i;

	// ------------------------------------------------------------
	// programmed state
	// ------------------------------------------------------------

	pend_state_type pend_q;        // which pair awaits its data byte
	logic           partial_q;     // partial display mode flag
	duty_code_type  req_duty_q;    // requested partial duty
	bias_code_type  bias_q;        // partial mode bias
	logic [5:0]     start_q;       // programmed partial start line
	logic           inv_en_q;      // line inversion switched on
	logic [4:0]     inv_count_q;   // stored spacing minus one
	logic [3:0]     pump_div_q;    // pump divider select

	// plain-command decode, valid only when no pair is pending
	logic plain_cmd;     // byte decoded as a fresh command
	logic is_duty;       // valid duty code 30h..34h
	logic is_bias;       // valid bias code 38h..3Dh

	assign plain_cmd = cmd_take && (pend_q == PEND_NONE);

	// reserved codes 35h..37h and 3Eh..3Fh fall outside both ranges
	// and therefore leave every register as it was
	assign is_duty = (wr_byte_i >= `OP_DUTY_BASE)
		&& (wr_byte_i <= `OP_DUTY_LAST);
	assign is_bias = (wr_byte_i >= `OP_BIAS_BASE)
		&& (wr_byte_i <= `OP_BIAS_LAST);

	// ------------------------------------------------------------
	// two-byte pair sequencer
	// ------------------------------------------------------------

	// an opening opcode arms one pending state; the very next command
	// byte, whatever its value, is consumed as that pair's data
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			pend_q <= PEND_NONE;
		end else if (cmd_take) begin
			case (pend_q)
				PEND_NONE: begin
					if (wr_byte_i == `OP_START_SET) begin
						pend_q <= PEND_START;
					end else if (wr_byte_i == `OP_INV_SET) begin
						pend_q <= PEND_INV;
					end else if (wr_byte_i == `OP_PUMP_SET) begin
						pend_q <= PEND_PUMP;
					end else begin
						pend_q <= PEND_NONE;
					end
				end
				// data byte consumed, back to normal decoding
				PEND_START,
				PEND_INV,
				PEND_PUMP: begin
					pend_q <= PEND_NONE;
				end
				// illegal codes recover to idle
				default: begin
					pend_q <= PEND_NONE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// display mode
	// ------------------------------------------------------------

	// mode switch; blocked while a pair waits for its data byte
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			partial_q <= 1'b0;
		end else if (plain_cmd && wr_byte_i == `OP_MODE_PARTIAL) begin
			partial_q <= 1'b1;
		end else if (plain_cmd && wr_byte_i == `OP_MODE_NORMAL) begin
			partial_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// partial duty and bias
	// ------------------------------------------------------------

	// duty loads pull the matching bias along; both are dropped in
	// normal mode so a stray command cannot leak into a later switch
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			req_duty_q <= `RST_DUTY;
			bias_q     <= `RST_BIAS;
		end else if (plain_cmd && partial_q) begin
			if (is_duty) begin
				req_duty_q <= wr_byte_i[2:0];
				case (wr_byte_i[2:0])
					`DUTY_9:  bias_q <= `BIAS_FOR_9;
					`DUTY_17: bias_q <= `BIAS_FOR_17;
					`DUTY_33: bias_q <= `BIAS_FOR_33;
					`DUTY_49: bias_q <= `BIAS_FOR_49;
					default:  bias_q <= `BIAS_FOR_65;
				endcase
			end else if (is_bias) begin
				bias_q <= wr_byte_i[2:0];
			end
		end
	end

	// ------------------------------------------------------------
	// partial start line
	// ------------------------------------------------------------

	// second byte of the D3h pair; top two bits are don't-care
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			start_q <= `RST_START;
		end else if (cmd_take && pend_q == PEND_START) begin
			start_q <= wr_byte_i[`START_MSB:0];
		end
	end

	// ------------------------------------------------------------
	// line inversion
	// ------------------------------------------------------------

	// count byte loads and arms inversion; 84h drops back to frame
	// inversion but keeps the count for a later re-arm
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			inv_en_q    <= 1'b0;
			inv_count_q <= `RST_INV_COUNT;
		end else if (cmd_take && pend_q == PEND_INV) begin
			inv_en_q    <= 1'b1;
			inv_count_q <= wr_byte_i[`INV_MSB:0];
		end else if (plain_cmd && wr_byte_i == `OP_INV_RELEASE) begin
			inv_en_q    <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// charge pump divider
	// ------------------------------------------------------------

	// divider byte of the E6h pair, low four bits only
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			pump_div_q <= `RST_PUMP_DIV;
		end else if (cmd_take && pend_q == PEND_PUMP) begin
			pump_div_q <= wr_byte_i[`PUMP_MSB:0];
		end
	end

	// ------------------------------------------------------------
	// effective drive settings
	// ------------------------------------------------------------

	duty_code_type eff_duty;    // duty after mode and pin limit
	logic [6:0]    eff_lines;   // lines scanned at that duty
	logic [5:0]    eff_start;   // start line after range check
	logic          short_duty;  // duty too short for line inversion
	logic          com_in_win;  // current common inside window
	logic [6:0]    com_rel;     // common index relative to start

	duty_limit u_duty_limit (
		.partial_mode_i    (partial_q),
		.req_duty_i        (req_duty_q),
		.req_start_i       (start_q),
		.max_duty_pin_lo_i (max_duty_pin_lo_i),
		.max_duty_pin_hi_i (max_duty_pin_hi_i),
		.eff_duty_o        (eff_duty),
		.eff_lines_o       (eff_lines),
		.eff_start_o       (eff_start)
	);

	// 1/9 and 1/17 only reachable in partial mode
	assign short_duty = partial_q
		&& (eff_duty == `DUTY_9 || eff_duty == `DUTY_17);

	// wraps high when com_line_i sits below the start, which lands
	// it outside the window without a second compare
	assign com_rel = com_line_i - {1'b0, eff_start};

	// icon common is always scanned; others only inside the window
	always_comb begin
		if (com_line_i == `ICON_COM) begin
			com_in_win = 1'b1;
		end else if (partial_q) begin
			com_in_win = (com_rel < eff_lines);
		end else begin
			com_in_win = (com_line_i < eff_lines);
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------

	// everything leaving the block is a flop, one cycle behind state,
	// so the driver side never sees decode glitches
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			partial_mode_o   <= 1'b0;
			duty_o           <= `RST_DUTY;
			partial_bias_o   <= `RST_BIAS;
			scan_lines_o     <= `LINES_65;
			start_line_o     <= `RST_START;
			pair_pending_o   <= 1'b0;
		end else begin
			partial_mode_o   <= partial_q;
			duty_o           <= eff_duty;
			partial_bias_o   <= bias_q;
			scan_lines_o     <= eff_lines;
			start_line_o     <= eff_start;
			pair_pending_o   <= (pend_q != PEND_NONE);
		end
	end

	// inversion drive: frame inversion whenever disabled or short duty
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			line_inv_en_o    <= 1'b0;
			line_inv_lines_o <= 6'h01;
		end else begin
			line_inv_en_o    <= inv_en_q && !short_duty;
			line_inv_lines_o <= {1'b0, inv_count_q} + 6'h01;
		end
	end

	// common select for the scan position presented this cycle
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			com_select_o         <= 1'b0;
			icon_common_output_o <= 1'b0;
		end else begin
			com_select_o         <= com_in_win;
			icon_common_output_o <= (com_line_i == `ICON_COM);
		end
	end

	// pump enable pulse; divider output is already a flop
	pump_divider u_pump_divider (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.osc_tick_i  (osc_tick_i),
		.div_sel_i   (pump_div_q),
		.pump_tick_o (pump_tick_o)
	);

endmodule

// >>> sim/pdi_properties.sv
// port-level assertions for the partial display command decoder
`timescale 1ns/100ps
module pdi_properties
	import pdi_pkg::*;
(
	input wire logic          ref_clk_i,
	input wire logic          reset_n_i,
	input wire logic          wr_strobe_i,
	input wire logic          command_data_select_i,
	input wire logic [7:0]    wr_byte_i,
	input wire logic          max_duty_pin_lo_i,
	input wire logic          max_duty_pin_hi_i,
	input wire logic          osc_tick_i,
	input wire logic [6:0]    com_line_i,
	input wire logic          partial_mode_o,
	input wire duty_code_type duty_o,
	input wire bias_code_type partial_bias_o,
	input wire logic          line_inv_en_o,
	input wire logic [5:0]    line_inv_lines_o,
	input wire logic          pair_pending_o,
	input wire logic          com_select_o,
	input wire logic          icon_common_output_o,
	input wire logic          pump_tick_o
);
	logic       cmd_w;    // a command byte is taken this edge
	logic [2:0] pin_duty; // duty ceiling from the straps
	logic       pend_m;   // pair state rebuilt from the write port
	assign cmd_w = wr_strobe_i && !command_data_select_i;
	// own copy of the pair state; pair_pending_o trails it by one edge,
	// so it cannot tell whether a byte arriving right now is data
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			pend_m <= 1'b0;
		end else if (cmd_w) begin
			pend_m <= !pend_m && (wr_byte_i inside {8'hD3, 8'h85, 8'hE6});
		end
	end
	assign pin_duty = max_duty_pin_hi_i ? 3'h4 : (max_duty_pin_lo_i ? 3'h3 : 3'h2);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// two samples with steady straps, since the straps may move at run time
	sequence s_pins;
		$stable(pin_duty) ##1 $stable(pin_duty);
	endsequence
	property p_pend_set;
		cmd_w && !pend_m && (wr_byte_i inside {8'hD3, 8'h85, 8'hE6}) |=> ##1 pair_pending_o;
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("opcode did not open a pair");
	property p_pend_hold;
		pend_m && !cmd_w |=> ##1 pair_pending_o;
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("pair dropped without byte");
	property p_pend_take;
		pend_m && cmd_w |=> ##1 !pair_pending_o;
	endproperty
	a_pend_take: assert property (p_pend_take) else $error("pair not closed by byte");
	property p_mode_on;
		cmd_w && !pend_m && wr_byte_i == 8'h83 |=> ##1 partial_mode_o;
	endproperty
	a_mode_on: assert property (p_mode_on) else $error("partial mode not entered");
	property p_clamp;
		s_pins |-> duty_o <= pin_duty;
	endproperty
	a_clamp: assert property (p_clamp) else $error("duty above strap limit");
	property p_normal;
		(!partial_mode_o && $stable(pin_duty)) [*2] |-> duty_o == pin_duty;
	endproperty
	a_normal: assert property (p_normal) else $error("normal duty not from straps");
	property p_bias;
		partial_bias_o <= 3'h5;
	endproperty
	a_bias: assert property (p_bias) else $error("bias code out of range");
	property p_inv_lines;
		line_inv_lines_o >= 6'h01 && line_inv_lines_o <= 6'h20;
	endproperty
	a_inv_lines: assert property (p_inv_lines) else $error("inversion span out of range");
	property p_frame;
		(duty_o <= 3'h1) [*2] |-> !line_inv_en_o;
	endproperty
	a_frame: assert property (p_frame) else $error("line inversion at short duty");
	property p_icon;
		com_line_i == 7'h40 |=> icon_common_output_o && com_select_o;
	endproperty
	a_icon: assert property (p_icon) else $error("icon common not selected");
	property p_pump;
		pump_tick_o |-> $past(osc_tick_i);
	endproperty
	a_pump: assert property (p_pump) else $error("pump tick without oscillator tick");
	c_pair: cover property (pair_pending_o && cmd_w);
	c_inv: cover property (line_inv_en_o);
	c_pump: cover property (pump_tick_o);
endmodule

// >>> sim/host_model.sv
// host processor model writing bytes into the decoder
`timescale 1ns/100ps
module host_model (
	input  wire logic ref_clk_i,
	output logic      wr_strobe_o,
	output logic      data_sel_o,
	output logic [7:0] wr_byte_o
);
	// bus idle at time zero
	initial begin
		wr_strobe_o = 1'b0;
		data_sel_o = 1'b1;
		wr_byte_o = 8'h00;
	end
	// one byte per cycle; the strobe stays up until idle() drops it, so back-to-back puts write on back-to-back cycles
	task put(input logic [7:0] b, input logic d);
		@(negedge ref_clk_i);
		wr_strobe_o = 1'b1;
		data_sel_o = d;
		wr_byte_o = b;
	endtask
	// released bus shows the inverse so stale data is never mistaken for valid
	task idle();
		@(negedge ref_clk_i);
		wr_strobe_o = 1'b0;
		wr_byte_o = ~wr_byte_o;
	endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the partial display command decoder
`timescale 1ns/100ps
module tb_top;
	logic        ref_clk_i, reset_n_i, wr_strobe_i, command_data_select_i, osc_tick_i;
	logic        max_duty_pin_lo_i, max_duty_pin_hi_i, partial_mode_o, line_inv_en_o;
	logic        pair_pending_o, com_select_o, icon_common_output_o, pump_tick_o;
	logic [7:0]  wr_byte_i;
	logic [6:0]  com_line_i, scan_lines_o;
	logic [2:0]  duty_o, partial_bias_o;
	logic [5:0]  start_line_o, line_inv_lines_o;
	logic [31:0] lfsr = 32'h7CC19EB2; // random source, fixed seed
	logic        osc_rand = 1'b1;     // low while the pump period is measured
	int          mode, rduty, bias, start, en, cnt, pend, pmax, ed, est;
	int          fail_count, total_checks, cycles;
	int          dv_tab[4] = '{0, 1, 15, 245};
	host_model host (.ref_clk_i, .wr_strobe_o(wr_strobe_i), .data_sel_o(command_data_select_i),
		.wr_byte_o(wr_byte_i));
	partial_display_inversion_cmds dut (.ref_clk_i, .reset_n_i, .wr_strobe_i,
		.command_data_select_i, .wr_byte_i, .max_duty_pin_lo_i, .max_duty_pin_hi_i, .osc_tick_i,
		.com_line_i, .partial_mode_o, .duty_o, .partial_bias_o, .scan_lines_o, .start_line_o,
		.line_inv_en_o, .line_inv_lines_o, .pair_pending_o, .com_select_o,
		.icon_common_output_o, .pump_tick_o);
	// 10 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// next state of the random source
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// oscillator ticks are random except while a pump period is timed
	always @(negedge ref_clk_i) begin
		lfsr <= lfsr_next(lfsr);
		osc_tick_i <= osc_rand ? lfsr[0] : 1'b1;
	end
	// hang guard
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task check(input logic [7:0] seen, input int exp);
		total_checks++;
		if (seen !== 8'(exp)) begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, 8'(exp));
		end
	endtask
	// reset the device and the model together; two cycles in reset
	task rst();
		reset_n_i = 1'b0;
		{mode, en, cnt, pend, start} = '0;
		rduty = 4;
		bias = 5;
		repeat (2) @(negedge ref_clk_i);
		reset_n_i = 1'b1;
	endtask
	// write one command byte and step the model
	task cmd(input logic [7:0] b);
		int p;
		host.put(b, 1'b0);
		p = pend;
		pend = 0;
		case (p)
			1: start = b[5:0];
			2: begin
				cnt = b[4:0];
				en = 1;
			end
			3: ;
			default: begin
				if (mode != 0 && b >= 8'h30 && b <= 8'h34) begin
					rduty = b - 8'h30;
					bias = rduty == 4 ? 5 : rduty;
				end
				if (mode != 0 && b >= 8'h38 && b <= 8'h3D)
					bias = b - 8'h38;
				if (b == 8'h82 || b == 8'h83)
					mode = b[0];
				if (b == 8'h84)
					en = 0;
				pend = b == 8'hD3 ? 1 : (b == 8'h85 ? 2 : (b == 8'hE6 ? 3 : 0));
			end
		endcase
	endtask
	// release the bus, let results settle, compare every level output except the common selects
	task cmp_all();
		host.idle();
		repeat (3) @(negedge ref_clk_i);
		pmax = max_duty_pin_hi_i ? 4 : (max_duty_pin_lo_i ? 3 : 2);
		ed = mode == 0 ? pmax : (rduty > pmax ? pmax : rduty);
		est = start >= 16 * pmax ? 0 : start;
		check(partial_mode_o, mode);
		check(duty_o, ed);
		check(partial_bias_o, bias);
		check(scan_lines_o, ed < 2 ? 8 << ed : 16 * ed);
		check(start_line_o, est);
		check(line_inv_en_o, en != 0 && ed > 1);
		check(line_inv_lines_o, cnt + 1);
		check(pair_pending_o, pend != 0);
	endtask
	// walk every common and compare selection against the displayed window
	task com_sweep();
		int lo;
		lo = mode != 0 ? est : 0;
		for (int c = 0; c <= 64; c++) begin
			com_line_i = 7'(c);
			@(negedge ref_clk_i);
			check(com_select_o, c == 64 || (c >= lo && c < lo + (ed < 2 ? 8 << ed : 16 * ed)));
			check(icon_common_output_o, c == 64);
		end
	endtask
	// time the gap between pump ticks with the oscillator ticking every cycle
	task pump_period(input int n);
		int c;
		osc_rand = 1'b0;
		repeat (3) begin
			c = 0;
			do begin
				@(negedge ref_clk_i);
				c++;
			end while (pump_tick_o !== 1'b1 && c < 100);
		end
		check(8'(c), n == 0 ? 1 : 2 * n);
		osc_rand = 1'b1;
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		{fail_count, total_checks, cycles} = '0;
		{max_duty_pin_hi_i, max_duty_pin_lo_i} = 2'b10;
		com_line_i = 7'h00;
		osc_tick_i = 1'b0;
		rst();
		cmp_all();
		pump_period(3);
		cmd(8'h30);
		cmd(8'h3A);
		cmp_all();
		cmd(8'h83);
		cmp_all();
		for (int b = 8'h30; b <= 8'h3F; b++) begin
			cmd(8'(b));
			cmp_all();
		end
		max_duty_pin_hi_i = 1'b0;
		max_duty_pin_lo_i = 1'b1;
		cmd(8'h33);
		cmd(8'h34);
		cmp_all();
		cmd(8'hD3);
		cmp_all();
		host.put(8'h55, 1'b1);
		cmd(8'hC5);
		cmd(8'hD3);
		cmd(8'h83);
		cmp_all();
		cmd(8'hD3);
		cmd(8'h3A);
		cmp_all();
		foreach (dv_tab[i]) begin
			cmd(8'h85);
			cmd(8'(dv_tab[i] + 8'h07));
			cmp_all();
			cmd(8'(8'h30 + i));
			cmp_all();
			cmd(8'hE6);
			cmd(8'(dv_tab[i]));
			cmp_all();
			pump_period(dv_tab[i] & 15);
		end
		cmd(8'h84);
		cmd(8'h31);
		cmd(8'hD3);
		cmd(8'h28);
		cmp_all();
		com_sweep();
		cmd(8'h82);
		cmp_all();
		com_sweep();
		{max_duty_pin_hi_i, max_duty_pin_lo_i} = 2'b00;
		cmp_all();
		repeat (40) begin
			if (lfsr[3])
				host.put(lfsr[15:8], 1'b1);
			else
				cmd(lfsr[15:8]);
			cmp_all();
		end
		rst();
		cmp_all();
		conclude();
	end
endmodule
bind partial_display_inversion_cmds pdi_properties u_chk (.ref_clk_i, .reset_n_i, .wr_strobe_i,
	.command_data_select_i, .wr_byte_i, .max_duty_pin_lo_i, .max_duty_pin_hi_i, .osc_tick_i,
	.com_line_i, .partial_mode_o, .duty_o, .partial_bias_o, .line_inv_en_o, .line_inv_lines_o,
	.pair_pending_o, .com_select_o, .icon_common_output_o, .pump_tick_o);
